// *** pics_pkg.sv ***
package pics_pkg;
    // Functional notes
    // - Control space reached only by dedicated instructions
    // - Read-only identification byte at address 0x0F
    // - Guard field selects idle bits before transmitting
    // - No extra idle going from transmit to receive
    // - Receive-to-transmit idle is guard plus two
    // - Guard codes 0..7 give 128 down to 0
    // - Guard field resets to zero, longest guard
    // - Programmer should set shortest safe guard time
    // - Reserved status and guard bits read zero
    // - Status bit 1 shows programming enabled
    // - Programmer polls enable bit before memory access
    // - Writing zero to enable bit disables programming
    // - Load opcode 1000 plus address returns byte
    // - Store opcode 1100 plus address writes next byte
    // - Only the correct 64-bit key sets enable

    // Control space addresses and fields
    localparam logic [3:0]  CSS_STATUS   = 4'h0;
    localparam logic [3:0]  CSS_GUARD    = 4'h2;
    localparam logic [3:0]  CSS_IDENT    = 4'hF;
    localparam int          STAT_EN_BIT  = 1;
    localparam logic [2:0]  GUARD_RESET  = 3'h0;
    // Instruction encodings
    localparam logic [3:0]  OP_LOAD      = 4'h8;
    localparam logic [3:0]  OP_STORE     = 4'hC;
    localparam logic [7:0]  OP_KEY       = 8'hE0;
    localparam logic [63:0] ENABLE_KEY   = 64'h1289_AB45_CDD8_88FF;
    localparam logic [2:0]  KEY_LAST     = 3'h7;
    // Frame: start, 8 data LSB first, 2 stop
    localparam logic [7:0]  FRAME_BITS   = 8'h0B;
    localparam logic [7:0]  STOP_BITS    = 8'h02;
    localparam logic [7:0]  GUARD_FIXED  = 8'h02;
    // Link clock made by the programmer
    localparam int          ACLK_NS      = 5;
    localparam int          LINK_NS      = 80;
    localparam logic [7:0]  LINK_HALF    = 8'(LINK_NS / (2 * ACLK_NS));
    // Programmer register map over AXI4-Lite
    localparam logic [3:0]  REG_CMD      = 4'h0;
    localparam logic [3:0]  REG_STAT     = 4'h4;
    localparam int          CMD_REPLY    = 8;
    localparam int          STAT_BUSY    = 0;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // Extra idle bits for a guard selection
    function automatic logic [7:0] pics_guard_bits(input logic [2:0] sel);
        return (sel == 3'h7) ? 8'h00 : (8'h80 >> sel);
    endfunction : pics_guard_bits
endpackage : pics_pkg

// *** pics_link_if.sv ***
`timescale 1ns/1ps
interface pics_link_if;
    logic link_clk;
    logic prog_dat_o;
    logic prog_dat_oe;
    logic dev_dat_o;
    logic dev_dat_oe;
    logic dat;

    // Shared data line with pull-up
    assign dat = prog_dat_oe ? prog_dat_o : (dev_dat_oe ? dev_dat_o : 1'b1);

    modport prog (
        output link_clk,
        output prog_dat_o,
        output prog_dat_oe,
        input  dat
    );
    modport dev (
        input  link_clk,
        input  dat,
        output dev_dat_o,
        output dev_dat_oe
    );
endinterface : pics_link_if

// *** pics_dev.sv ***
`timescale 1ns/1ps
module pics_dev
    import pics_pkg::*;
#(
    parameter logic [7:0] ID_CODE = 8'h5A // Arbitrary value
) (
    input  wire logic  aclk,
    input  wire logic  aresetn,
    pics_link_if.dev   link,
    output logic [2:0] guard_time_sel,
    output logic       nvm_prog_enabled
);

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_DATA  = 3'b001,
        ST_STOP  = 3'b010,
        ST_GUARD = 3'b011,
        ST_SEND  = 3'b100
    } pics_dev_state_e;

    typedef enum logic [1:0] {
        CX_INSTR = 2'b00,
        CX_STORE = 2'b01,
        CX_KEY   = 2'b10
    } pics_dev_ctx_e;

    // Synchronisers
    logic            clk_s1_ff;
    logic            clk_s2_ff;
    logic            clk_s3_ff;
    logic            dat_s1_ff;
    logic            dat_s2_ff;
    logic            rise;
    logic            fall;
    // Link state
    pics_dev_state_e state_ff,  nxt_state;
    pics_dev_ctx_e   ctx_ff,    nxt_ctx;
    logic [7:0]      cnt_ff,    nxt_cnt;
    logic [7:0]      sh_ff,     nxt_sh;
    logic [10:0]     tx_ff,     nxt_tx;
    logic [3:0]      addr_ff,   nxt_addr;
    logic [63:0]     key_ff,    nxt_key;
    logic [2:0]      kcnt_ff,   nxt_kcnt;
    logic            dat_o_ff,  nxt_dat_o;
    logic            dat_oe_ff, nxt_dat_oe;
    // Control space registers
    logic            en_ff,     nxt_en;
    logic [2:0]      gt_ff,     nxt_gt;
    logic [63:0]     key_full;

    // Control space read decode
    function automatic logic [7:0] css_read(
        input logic [3:0] a,
        input logic       en,
        input logic [2:0] gt
    );
        logic [7:0] v;
        v = 8'h00;
        case (a)
            CSS_STATUS: v[STAT_EN_BIT] = en;
            CSS_GUARD:  v[2:0] = gt;
            CSS_IDENT:  v = ID_CODE;
            default:    v = 8'h00;
        endcase
        return v;
    endfunction : css_read

    // Two flops on the link pins, a third on the clock for edge detect
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_s1_ff <= 1'b0;
            clk_s2_ff <= 1'b0;
            clk_s3_ff <= 1'b0;
            dat_s1_ff <= 1'b1;
            dat_s2_ff <= 1'b1;
        end else begin
            clk_s1_ff <= link.link_clk;
            clk_s2_ff <= clk_s1_ff;
            clk_s3_ff <= clk_s2_ff;
            dat_s1_ff <= link.dat;
            dat_s2_ff <= dat_s1_ff;
        end
    end

    // Link clock edges
    assign rise     = clk_s2_ff & ~clk_s3_ff;
    assign fall     = ~clk_s2_ff & clk_s3_ff;
    assign key_full = {sh_ff, key_ff[63:8]};

    // Frame reception, decode and reply
    always_comb begin
        nxt_state  = state_ff;
        nxt_ctx    = ctx_ff;
        nxt_cnt    = cnt_ff;
        nxt_sh     = sh_ff;
        nxt_tx     = tx_ff;
        nxt_addr   = addr_ff;
        nxt_key    = key_ff;
        nxt_kcnt   = kcnt_ff;
        nxt_dat_o  = dat_o_ff;
        nxt_dat_oe = dat_oe_ff;
        nxt_en     = en_ff;
        nxt_gt     = gt_ff;
        case (state_ff)
            ST_IDLE: begin
                if (rise && !dat_s2_ff) begin
                    nxt_state = ST_DATA;
                    nxt_cnt   = 8'h00;
                end
            end
            ST_DATA: begin
                if (rise) begin
                    nxt_sh  = {dat_s2_ff, sh_ff[7:1]};
                    nxt_cnt = cnt_ff + 8'h01;
                    if (cnt_ff == 8'h07) begin
                        nxt_state = ST_STOP;
                        nxt_cnt   = 8'h00;
                    end
                end
            end
            ST_STOP: begin
                if (rise && cnt_ff != STOP_BITS - 8'h01) begin
                    nxt_cnt = cnt_ff + 8'h01;
                end else if (rise) begin
                    nxt_state = ST_IDLE;
                    case (ctx_ff)
                        CX_INSTR: begin
                            // Only control-space load/store and key opcodes act here
                            if (sh_ff[7:4] == OP_LOAD) begin
                                nxt_tx    = {2'b11, css_read(sh_ff[3:0], en_ff, gt_ff), 1'b0};
                                nxt_state = ST_GUARD;
                                nxt_cnt   = pics_guard_bits(gt_ff) + GUARD_FIXED;
                            end else if (sh_ff[7:4] == OP_STORE) begin
                                nxt_ctx  = CX_STORE;
                                nxt_addr = sh_ff[3:0];
                            end else if (sh_ff == OP_KEY) begin
                                nxt_ctx  = CX_KEY;
                                nxt_kcnt = 3'h0;
                            end
                        end
                        CX_STORE: begin
                            nxt_ctx = CX_INSTR;
                            // Enable only cleared by a write
                            if (addr_ff == CSS_STATUS && !sh_ff[STAT_EN_BIT]) begin
                                nxt_en = 1'b0;
                            end
                            if (addr_ff == CSS_GUARD) begin
                                nxt_gt = sh_ff[2:0];
                            end
                        end
                        CX_KEY: begin
                            nxt_key  = key_full;
                            nxt_kcnt = kcnt_ff + 3'h1;
                            if (kcnt_ff == KEY_LAST) begin
                                nxt_ctx = CX_INSTR;
                                if (key_full == ENABLE_KEY) begin
                                    nxt_en = 1'b1;
                                end
                            end
                        end
                        default: nxt_ctx = CX_INSTR;
                    endcase
                end
            end
            ST_GUARD: begin
                // Idle bits counted on link clock rises
                if (rise) begin
                    nxt_cnt = cnt_ff - 8'h01;
                    if (cnt_ff == 8'h01) begin
                        nxt_state = ST_SEND;
                        nxt_cnt   = 8'h00;
                    end
                end
            end
            ST_SEND: begin
                if (fall) begin
                    if (cnt_ff == FRAME_BITS) begin
                        nxt_dat_oe = 1'b0;
                        nxt_state  = ST_IDLE;
                    end else begin
                        nxt_dat_oe = 1'b1;
                        nxt_dat_o  = tx_ff[cnt_ff[3:0]];
                        nxt_cnt    = cnt_ff + 8'h01;
                    end
                end
            end
            default: begin
                nxt_state  = ST_IDLE;
                nxt_dat_oe = 1'b0;
            end
        endcase
    end

    // Link and register state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff  <= ST_IDLE;
            ctx_ff    <= CX_INSTR;
            cnt_ff    <= 8'h00;
            sh_ff     <= 8'h00;
            tx_ff     <= 11'h7FF;
            addr_ff   <= 4'h0;
            key_ff    <= 64'h0000_0000_0000_0000;
            kcnt_ff   <= 3'h0;
            dat_o_ff  <= 1'b1;
            dat_oe_ff <= 1'b0;
            en_ff     <= 1'b0;
            gt_ff     <= GUARD_RESET;
        end else begin
            state_ff  <= nxt_state;
            ctx_ff    <= nxt_ctx;
            cnt_ff    <= nxt_cnt;
            sh_ff     <= nxt_sh;
            tx_ff     <= nxt_tx;
            addr_ff   <= nxt_addr;
            key_ff    <= nxt_key;
            kcnt_ff   <= nxt_kcnt;
            dat_o_ff  <= nxt_dat_o;
            dat_oe_ff <= nxt_dat_oe;
            en_ff     <= nxt_en;
            gt_ff     <= nxt_gt;
        end
    end

    // Outputs straight from flops
    assign link.dev_dat_o   = dat_o_ff;
    assign link.dev_dat_oe  = dat_oe_ff;
    assign guard_time_sel   = gt_ff;
    assign nvm_prog_enabled = en_ff;

endmodule : pics_dev

// *** pics_prog.sv ***
`timescale 1ns/1ps
module pics_prog
    import pics_pkg::*;
#(
    parameter logic [7:0] HALF_CYC = LINK_HALF
) (
    input  wire logic   aclk,
    input  wire logic   aresetn,
    pics_link_if.prog   link,
    input  wire logic   s_axi_awvalid,
    output logic        s_axi_awready,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic   s_axi_wvalid,
    output logic        s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic        s_axi_bvalid,
    input  wire logic   s_axi_bready,
    output logic [1:0]  s_axi_bresp,
    input  wire logic   s_axi_arvalid,
    output logic        s_axi_arready,
    input  wire logic [3:0]  s_axi_araddr,
    output logic        s_axi_rvalid,
    input  wire logic   s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0]  s_axi_rresp
);

    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_SEND = 2'b01,
        H_WAIT = 2'b10,
        H_RECV = 2'b11
    } pics_prog_state_e;

    // Bus slave state
    logic             awr_ff, nxt_awr, aw_ff, nxt_aw;
    logic             wr_ff,  nxt_wr,  w_ff,  nxt_w;
    logic [3:0]       wa_ff,  nxt_wa;
    logic [9:0]       wd_ff,  nxt_wd;
    logic             bv_ff,  nxt_bv;
    logic [1:0]       br_ff,  nxt_br;
    logic             arr_ff, nxt_arr;
    logic             rv_ff,  nxt_rv;
    logic [31:0]      rd_ff,  nxt_rd;
    logic [1:0]       rr_ff,  nxt_rr;
    logic             go;
    // Link state
    logic [7:0]       div_ff, nxt_div;
    logic             lclk_ff, nxt_lclk;
    logic             d_s1_ff;
    logic             d_s2_ff;
    pics_prog_state_e st_ff,  nxt_st;
    logic [7:0]       cnt_ff, nxt_cnt;
    logic [10:0]      tx_ff,  nxt_tx;
    logic             rep_ff, nxt_rep;
    logic [7:0]       rx_ff,  nxt_rx;
    logic             do_ff,  nxt_do;
    logic             doe_ff, nxt_doe;
    logic             rise;
    logic             fall;

    // Write commit when address and data are both held
    assign go = aw_ff && w_ff && !bv_ff;

    // AXI4-Lite slave
    always_comb begin
        nxt_aw  = aw_ff;
        nxt_w   = w_ff;
        nxt_wa  = wa_ff;
        nxt_wd  = wd_ff;
        nxt_bv  = bv_ff;
        nxt_br  = br_ff;
        nxt_rv  = rv_ff;
        nxt_rd  = rd_ff;
        nxt_rr  = rr_ff;
        if (s_axi_awvalid && awr_ff) begin
            nxt_aw = 1'b1;
            nxt_wa = s_axi_awaddr;
        end
        if (s_axi_wvalid && wr_ff) begin
            nxt_w  = 1'b1;
            nxt_wd = {s_axi_wstrb != 4'h0, s_axi_wdata[8:0]};
        end
        if (go) begin
            nxt_aw = 1'b0;
            nxt_w  = 1'b0;
            nxt_bv = 1'b1;
            nxt_br = (wa_ff == REG_CMD && st_ff == H_IDLE) ? RESP_OKAY : RESP_SLVERR;
        end
        if (bv_ff && s_axi_bready) begin
            nxt_bv = 1'b0;
        end
        if (s_axi_arvalid && arr_ff) begin
            nxt_rv  = 1'b1;
            nxt_rr  = RESP_OKAY;
            nxt_rd  = 32'h0000_0000;
            if (s_axi_araddr == REG_STAT) begin
                nxt_rd[15:8]      = rx_ff;
                nxt_rd[STAT_BUSY] = (st_ff != H_IDLE);
            end else if (s_axi_araddr != REG_CMD) begin
                nxt_rr = RESP_SLVERR;
            end
        end
        if (rv_ff && s_axi_rready) begin
            nxt_rv  = 1'b0;
        end
        nxt_awr = !nxt_aw;
        nxt_wr  = !nxt_w;
        nxt_arr = !nxt_rv;
    end

    // Link clock edges from the divider
    assign rise = (div_ff == HALF_CYC - 8'h01) && !lclk_ff;
    assign fall = (div_ff == HALF_CYC - 8'h01) && lclk_ff;

    // Link clock and frame sequencing
    always_comb begin
        nxt_div  = (div_ff == HALF_CYC - 8'h01) ? 8'h00 : div_ff + 8'h01;
        nxt_lclk = lclk_ff ^ (div_ff == HALF_CYC - 8'h01);
        nxt_st   = st_ff;
        nxt_cnt  = cnt_ff;
        nxt_tx   = tx_ff;
        nxt_rep  = rep_ff;
        nxt_rx   = rx_ff;
        nxt_do   = do_ff;
        nxt_doe  = doe_ff;
        case (st_ff)
            H_IDLE: begin
                if (go && wa_ff == REG_CMD && wd_ff[9]) begin
                    nxt_tx  = {2'b11, wd_ff[7:0], 1'b0};
                    nxt_rep = wd_ff[CMD_REPLY];
                    nxt_cnt = 8'h00;
                    nxt_st  = H_SEND;
                end
            end
            H_SEND: begin
                if (fall && cnt_ff == FRAME_BITS) begin
                    nxt_doe = 1'b0;
                    nxt_st  = rep_ff ? H_WAIT : H_IDLE;
                end else if (fall) begin
                    nxt_doe = 1'b1;
                    nxt_do  = tx_ff[cnt_ff[3:0]];
                    nxt_cnt = cnt_ff + 8'h01;
                end
            end
            H_WAIT: begin
                if (rise && !d_s2_ff) begin
                    nxt_st  = H_RECV;
                    nxt_cnt = 8'h00;
                end
            end
            H_RECV: begin
                if (rise) begin
                    nxt_cnt = cnt_ff + 8'h01;
                    if (cnt_ff < 8'h08) begin
                        nxt_rx = {d_s2_ff, rx_ff[7:1]};
                    end
                    if (cnt_ff == FRAME_BITS - 8'h02) begin
                        nxt_st = H_IDLE;
                    end
                end
            end
            default: nxt_st = H_IDLE;
        endcase
    end

    // Registered state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awr_ff  <= 1'b0;
            aw_ff   <= 1'b0;
            wr_ff   <= 1'b0;
            w_ff    <= 1'b0;
            wa_ff   <= 4'h0;
            wd_ff   <= 10'h000;
            bv_ff   <= 1'b0;
            br_ff   <= RESP_OKAY;
            arr_ff  <= 1'b0;
            rv_ff   <= 1'b0;
            rd_ff   <= 32'h0000_0000;
            rr_ff   <= RESP_OKAY;
            div_ff  <= 8'h00;
            lclk_ff <= 1'b0;
            d_s1_ff <= 1'b1;
            d_s2_ff <= 1'b1;
            st_ff   <= H_IDLE;
            cnt_ff  <= 8'h00;
            tx_ff   <= 11'h7FF;
            rep_ff  <= 1'b0;
            rx_ff   <= 8'h00;
            do_ff   <= 1'b1;
            doe_ff  <= 1'b0;
        end else begin
            awr_ff  <= nxt_awr;
            aw_ff   <= nxt_aw;
            wr_ff   <= nxt_wr;
            w_ff    <= nxt_w;
            wa_ff   <= nxt_wa;
            wd_ff   <= nxt_wd;
            bv_ff   <= nxt_bv;
            br_ff   <= nxt_br;
            arr_ff  <= nxt_arr;
            rv_ff   <= nxt_rv;
            rd_ff   <= nxt_rd;
            rr_ff   <= nxt_rr;
            div_ff  <= nxt_div;
            lclk_ff <= nxt_lclk;
            d_s1_ff <= link.dat;
            d_s2_ff <= d_s1_ff;
            st_ff   <= nxt_st;
            cnt_ff  <= nxt_cnt;
            tx_ff   <= nxt_tx;
            rep_ff  <= nxt_rep;
            rx_ff   <= nxt_rx;
            do_ff   <= nxt_do;
            doe_ff  <= nxt_doe;
        end
    end

    // Outputs straight from flops
    assign s_axi_awready    = awr_ff;
    assign s_axi_wready     = wr_ff;
    assign s_axi_bvalid     = bv_ff;
    assign s_axi_bresp      = br_ff;
    assign s_axi_arready    = arr_ff;
    assign s_axi_rvalid     = rv_ff;
    assign s_axi_rdata      = rd_ff;
    assign s_axi_rresp      = rr_ff;
    assign link.link_clk    = lclk_ff;
    assign link.prog_dat_o  = do_ff;
    assign link.prog_dat_oe = doe_ff;

endmodule : pics_prog

// *** pics_link_props.sv ***
`timescale 1ns/1ps
module pics_link_props
    import pics_pkg::*;
#(
    parameter logic [7:0] HALF_CYC = LINK_HALF
) (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       link_clk,
    input wire logic       prog_dat_o,
    input wire logic       prog_dat_oe,
    input wire logic       dev_dat_o,
    input wire logic       dev_dat_oe,
    input wire logic       dat,
    input wire logic [2:0] guard_time_sel,
    input wire logic       nvm_prog_enabled
);
    logic [15:0] idle_ff;
    logic [15:0] nxt_idle;
    logic [15:0] drv_ff;
    logic [15:0] nxt_drv;
    logic        lclk_ff;
    logic        rise;
    logic [15:0] guard_exp;

    // Own guard table and link clock rise detect
    assign rise      = link_clk & ~lclk_ff;
    assign guard_exp = (guard_time_sel == 3'h7) ? 16'h0000 : (16'h0080 >> guard_time_sel);

    // Idle ones since last zero on the line, cycles the device drives
    always_comb begin
        nxt_idle = idle_ff;
        if (rise && !dev_dat_oe) begin
            nxt_idle = dat ? idle_ff + 16'h0001 : 16'h0000;
        end
        nxt_drv = dev_dat_oe ? drv_ff + 16'h0001 : 16'h0000;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idle_ff <= 16'h0000;
            drv_ff  <= 16'h0000;
            lclk_ff <= 1'b0;
        end else begin
            idle_ff <= nxt_idle;
            drv_ff  <= nxt_drv;
            lclk_ff <= link_clk;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    rst_values_a: assert property (disable iff (1'b0) !aresetn |=>
        guard_time_sel == GUARD_RESET && !nvm_prog_enabled && !dev_dat_oe && !prog_dat_oe)
        else $error("reset values wrong");
    // Load opcode ends 0,1 then two stops: three ones before the guard
    guard_idle_a: assert property ($rose(dev_dat_oe) |-> idle_ff == guard_exp + 16'h0005)
        else $error("guard idle count wrong");
    host_quiet_a: assert property ($rose(dev_dat_oe) |-> !prog_dat_oe && $past(!prog_dat_oe))
        else $error("device drives over host");
    start_bit_a: assert property ($rose(dev_dat_oe) |-> !dev_dat_o)
        else $error("reply start bit not zero");
    reply_len_a: assert property ($fell(dev_dat_oe) |-> drv_ff == 16'(22 * int'(HALF_CYC)))
        else $error("reply length wrong");
    stop_bit_a: assert property ($fell(dev_dat_oe) |-> $past(dev_dat_o, 1))
        else $error("reply stop bit not one");
    guard_quiet_a: assert property ($changed(guard_time_sel) |-> !dev_dat_oe)
        else $error("guard changed while replying");
    enable_quiet_a: assert property ($changed(nvm_prog_enabled) |-> !dev_dat_oe)
        else $error("enable changed while replying");
endmodule : pics_link_props

// *** tb_prog_if_ctrl_status_space.sv ***
`timescale 1ns/1ps
module tb_prog_if_ctrl_status_space
    import pics_pkg::*;
();
    localparam logic [7:0] HALF   = 8'h04;
    localparam logic [7:0] ID_VAL = 8'hC3; // Arbitrary identity value
    localparam int         TMO    = 60000;
    logic        aclk;
    logic        aresetn;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, nvm;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, s;
    logic [1:0]  bresp, rresp, r;
    logic [2:0]  gsel;
    logic [7:0]  b;
    int          fails = 0;
    int          n_checks = 0;
    int          cyc = 0;

    pics_link_if link_bus ();

    pics_prog #(.HALF_CYC(HALF)) i_pics_prog (.aclk(aclk), .aresetn(aresetn), .link(link_bus.prog),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp));
    pics_dev #(.ID_CODE(ID_VAL)) i_pics_dev (.aclk(aclk), .aresetn(aresetn), .link(link_bus.dev),
        .guard_time_sel(gsel), .nvm_prog_enabled(nvm));
    pics_link_props #(.HALF_CYC(HALF)) i_pics_link_props (.aclk(aclk), .aresetn(aresetn),
        .link_clk(link_bus.link_clk), .prog_dat_o(link_bus.prog_dat_o), .prog_dat_oe(link_bus.prog_dat_oe),
        .dev_dat_o(link_bus.dev_dat_o), .dev_dat_oe(link_bus.dev_dat_oe), .dat(link_bus.dat),
        .guard_time_sel(gsel), .nvm_prog_enabled(nvm));

    // Clock
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Write, both channels offered together
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] exp);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr  <= a;
        wvalid  <= 1'b1;
        wdata   <= d;
        bready  <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awready && awvalid) awvalid <= 1'b0;
            if (wready && wvalid) wvalid <= 1'b0;
            if (bvalid && bready) begin
                bready <= 1'b0;
                done = 1'b1;
                chk("bresp", 32'(exp), 32'(bresp));
            end
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rr);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arready && arvalid) arvalid <= 1'b0;
            if (rvalid && rready) begin
                rready <= 1'b0;
                d = rdata;
                rr = rresp;
                done = 1'b1;
            end
        end
    endtask : axi_rd

    // Poll busy, return last received byte
    task automatic wait_idle(output logic [7:0] got);
        logic [31:0] st;
        logic [1:0]  rr;
        st = 32'h0000_0001;
        while (st[STAT_BUSY] !== 1'b0) axi_rd(REG_STAT, st, rr);
        got = st[15:8];
    endtask : wait_idle

    task automatic link_tx(input logic [7:0] d, input logic rep, output logic [7:0] got);
        axi_wr(REG_CMD, {23'h00_0000, rep, d}, RESP_OKAY);
        wait_idle(got);
    endtask : link_tx

    task automatic css_ld(input logic [3:0] a, output logic [7:0] got);
        link_tx({OP_LOAD, a}, 1'b1, got);
    endtask : css_ld

    task automatic css_st(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] x;
        link_tx({OP_STORE, a}, 1'b0, x);
        link_tx(d, 1'b0, x);
    endtask : css_st

    // Key instruction, then key bytes LSB first
    task automatic send_key(input logic [63:0] k);
        logic [7:0] x;
        link_tx(OP_KEY, 1'b0, x);
        for (int i = 0; i < 8; i++) link_tx(k[8*i +: 8], 1'b0, x);
    endtask : send_key

    // Watchdog
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == TMO) begin
            $display("mismatch watchdog expected %0d seen %0d", TMO, cyc);
            fails = fails + 1;
            test_done();
        end
    end

    // Main sequence
    initial begin
        aresetn = 1'b0;
        awvalid = 1'b0;
        wvalid  = 1'b0;
        bready  = 1'b0;
        arvalid = 1'b0;
        rready  = 1'b0;
        awaddr  = 4'h0;
        araddr  = 4'h0;
        wdata   = 32'h0000_0000;
        wstrb   = 4'hF;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("guard pin", 32'h0000_0000, 32'(gsel));
        chk("enable pin", 32'h0000_0000, 32'(nvm));
        css_ld(CSS_STATUS, b);
        chk("status", 32'h0000_0000, 32'(b));
        css_ld(CSS_GUARD, b);
        chk("guard", 32'h0000_0000, 32'(b));
        css_ld(CSS_IDENT, b);
        chk("ident", 32'(ID_VAL), 32'(b));
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            css_st(CSS_GUARD, 8'hF8 | 8'(i));
            chk("guard pin", 32'(i), 32'(gsel));
            css_ld(CSS_GUARD, b);
            chk("guard", 32'(i), 32'(b));
        end
        $display("test guard done");
        for (int a = 1; a < 15; a++) begin
            if (a != 2) begin
                css_st(4'(a), 8'hFF);
                css_ld(4'(a), b);
                chk("reserved", 32'h0000_0000, 32'(b));
            end
        end
        css_st(CSS_IDENT, 8'h00);
        css_ld(CSS_IDENT, b);
        chk("ident", 32'(ID_VAL), 32'(b));
        css_st(CSS_STATUS, 8'hFF);
        css_ld(CSS_STATUS, b);
        chk("status", 32'h0000_0000, 32'(b));
        $display("test reserved done");
        send_key({ENABLE_KEY[63:8], 8'h00});
        css_ld(CSS_STATUS, b);
        chk("bad key", 32'h0000_0000, 32'(b));
        send_key(ENABLE_KEY);
        b = 8'h00;
        for (int n = 0; n < 8 && b[STAT_EN_BIT] !== 1'b1; n++) css_ld(CSS_STATUS, b);
        chk("status", 32'h0000_0002, 32'(b));
        chk("enable pin", 32'h0000_0001, 32'(nvm));
        css_st(CSS_STATUS, 8'h00);
        chk("enable pin", 32'h0000_0000, 32'(nvm));
        css_ld(CSS_STATUS, b);
        chk("status", 32'h0000_0000, 32'(b));
        $display("test key done");
        axi_wr(4'h8, 32'h0000_0000, RESP_SLVERR);
        axi_rd(4'h8, s, r);
        chk("rresp", 32'(RESP_SLVERR), 32'(r));
        chk("rdata", 32'h0000_0000, s);
        axi_wr(REG_CMD, {24'h00_0001, OP_LOAD, CSS_IDENT}, RESP_OKAY);
        axi_wr(REG_CMD, 32'h0000_00FF, RESP_SLVERR);
        wait_idle(b);
        chk("ident", 32'(ID_VAL), 32'(b));
        wstrb <= 4'h0;
        axi_wr(REG_CMD, 32'h0000_00A5, RESP_OKAY);
        axi_rd(REG_STAT, s, r);
        chk("no strobe", {16'h0000, ID_VAL, 8'h00}, s);
        chk("rresp", 32'(RESP_OKAY), 32'(r));
        axi_rd(REG_CMD, s, r);
        chk("cmd read", 32'h0000_0000, s);
        $display("test bus done");
        test_done();
    end
endmodule : tb_prog_if_ctrl_status_space
